// [mtc_pins_model.sv]
// partner model: external enable and measure event pins
`timescale 1ns/1ps
module mtc_pins_model
(
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rst_i,
   // requests from the bench, one cycle each
   input  wire logic ext_go_i,
   input  wire logic meas_go_i,
   // pins toward the timer
   output logic      ext_enable_o,
   output logic      meas_event_o
);
   logic [2:0] ext_cnt_r;   // cycles left on the enable pin
   logic [2:0] meas_cnt_r;  // cycles left on the event pin

   ////////////////////////////////////////////////////////////////////////////////////////
   // pulses last 4 cycles so the two-flop syncs always catch them
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ext_cnt_r  <= 3'h0;
         meas_cnt_r <= 3'h0;
      end
      else
      begin
         ext_cnt_r  <= ext_go_i ? 3'h4 : ext_cnt_r - {2'h0, ext_cnt_r != 3'h0};
         meas_cnt_r <= meas_go_i ? 3'h4 : meas_cnt_r - {2'h0, meas_cnt_r != 3'h0};
      end
   end

   // pins rise on the edge that sees the request
   assign ext_enable_o = ext_cnt_r != 3'h0;
   assign meas_event_o = meas_cnt_r != 3'h0;
endmodule

// [mtc_pkg.sv]
// package: register map, field positions, modes and timing constants of the timer block
package mtc_pkg;
   // data and counter widths
   localparam int unsigned CNT_W   = 16;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned ADDR_W  = 8;
   localparam int unsigned PRE_W   = 8;

   // register byte addresses, one aligned word each
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] PRESC_ADDR  = 8'h04;
   localparam logic [7:0] RELOAD_ADDR = 8'h08;
   localparam logic [7:0] OCNT_ADDR   = 8'h0c;
   localparam logic [7:0] CORR_ADDR   = 8'h10;
   localparam logic [7:0] MCNT_ADDR   = 8'h14;
   localparam logic [7:0] MCAP_ADDR   = 8'h18;
   localparam logic [7:0] STAT_ADDR   = 8'h1c;
   localparam logic [7:0] IEN_ADDR    = 8'h20;
   localparam logic [7:0] ICLR_ADDR   = 8'h24;

   // control register fields
   localparam int unsigned OMODE_LSB  = 0;
   localparam int unsigned RUN_BIT    = 2;
   localparam int unsigned MMODE_LSB  = 4;
   localparam int unsigned CBUS_BIT   = 6;

   // status / enable / clear bit positions
   localparam int unsigned ST_W       = 2;
   localparam int unsigned ST_UF      = 0;
   localparam int unsigned ST_CAP     = 1;

   // prescaler divisor that gives half the peripheral clock
   localparam logic [PRE_W-1:0] PRE_HALF = 8'h01;

   // reset value, reload all-ones pattern and one-count step
   localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONES = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

   // output timer modes
   typedef enum logic [1:0] {
      OM_SINGLE  = 2'h0,
      OM_DELAYED = 2'h1,
      OM_CONT    = 2'h2
   } mtc_omode_t;

   // measure timer modes
   typedef enum logic [1:0] {
      MM_FREE  = 2'h0,
      MM_CLEAR = 2'h1,
      MM_LONG  = 2'h2
   } mtc_mmode_t;
endpackage

// [mtc_presc.sv]
// module: prescaler making the count-clock enable pulse
`timescale 1ns/1ps
module mtc_presc
(
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rst_i,
   // divisor in, tick out
   mtc_tick_if.src   tk
);
   logic [mtc_pkg::PRE_W-1:0] cnt_r;   // cycles since last tick
   logic                      tick_r;  // registered tick

   ////////////////////////////////////////////////////////////////
   // divider; a divisor change acts on the running count at once
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end
      else if (cnt_r >= tk.div)
      begin
         cnt_r  <= '0;
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 8'h01;
         tick_r <= 1'b0;
      end
   end

   assign tk.tick = tick_r;
endmodule

// [mtc_tick_if.sv]
// interface: prescaler divisor in, count-clock enable pulse out
`timescale 1ns/1ps
interface mtc_tick_if;
   logic [mtc_pkg::PRE_W-1:0] div;   // divide-by (div+1)
   logic                      tick;  // one-cycle count enable
   modport src (input div, output tick);
   modport snk (output div, input tick);
endinterface

// [mtc_timer.sv]
// module: output down-timer and measure up-timer with same-cycle collision handling
//
// What this block does
// - underflow stop beats external enable
// - software enable write beats underflow stop
// - software disable write beats external enable
// - correction overflow raises no interrupt
// - later underflow after correction still flags
// - counter reads all ones after reload
// - next edge counter becomes reload minus one
// - output flop starts one prescaler tick later
// - free/clear collision: write into both
// - long collision: capture pre-write count
// - off-rate clock bus capture leads one
`timescale 1ns/1ps
module mtc_timer
(
   // clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_i,
   // register port
   input  wire logic [mtc_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [mtc_pkg::DATA_W-1:0]  wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [mtc_pkg::DATA_W-1:0]  rdata_o,
   // pins
   input  wire logic                        ext_enable_i,
   input  wire logic                        meas_event_i,
   output logic                             timer_out_o,
   // interrupt
   output logic                             irq_o
);
   ////////////////////////////////////////////////////////////////
   // declarations
   mtc_tick_if tk ();                               // prescaler link

   logic [1:0]                      omode_r;        // output mode
   logic [1:0]                      mmode_r;        // measure mode
   logic                            cbus_r;         // clock bus one selected
   logic                            run_r;          // output timer enable
   logic                            run_nxt;
   logic                            first_r;        // waiting for first tick
   logic                            ff_act_r;       // output flop running
   logic                            ff_r;           // output flop
   logic                            rl_pend_r;      // ones shown, reload-1 due
   logic [mtc_pkg::PRE_W-1:0]       div_r;          // prescaler divisor
   logic [mtc_pkg::CNT_W-1:0]       reload_r;       // reload value
   logic [mtc_pkg::CNT_W-1:0]       ocnt_r;         // down counter
   logic [mtc_pkg::CNT_W-1:0]       mcnt_r;         // up counter
   logic [mtc_pkg::CNT_W-1:0]       mcap_r;         // measure register
   logic [mtc_pkg::ST_W-1:0]        stat_r;         // sticky events
   logic [mtc_pkg::ST_W-1:0]        ien_r;          // interrupt enables
   logic [mtc_pkg::DATA_W-1:0]      rdata_r;        // read data
   logic [2:0]                      ext_s_r;        // ext sync + edge stage
   logic [2:0]                      mev_s_r;        // event sync + edge stage
   logic                            ext_start;      // external enable edge
   logic                            mev;            // measure event edge
   logic                            uf;             // underflow this cycle
   logic                            uf_stop;        // underflow ends a shot
   logic                            ctrl_wr;        // control write strobe
   logic                            skew;           // capture leads by one
   logic [mtc_pkg::CNT_W-1:0]       cap_val;        // value to capture
   logic [mtc_pkg::ST_W-1:0]        ev_set;         // event pulses

   // true when the address hits a given register
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   ////////////////////////////////////////////////////////////////
   // prescaler
   assign tk.div = div_r;
   mtc_presc u_presc
   (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .tk      (tk)
   );

   ////////////////////////////////////////////////////////////////
   // pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ext_s_r <= 3'h0;
         mev_s_r <= 3'h0;
      end
      else
      begin
         ext_s_r <= {ext_s_r[1:0], ext_enable_i};
         mev_s_r <= {mev_s_r[1:0], meas_event_i};
      end
   end

   // rising edges, taken after the second flop
   assign ext_start = ext_s_r[1] & ~ext_s_r[2];
   assign mev       = mev_s_r[1] & ~mev_s_r[2];

   ////////////////////////////////////////////////////////////////
   // decode of the output timer events
   assign ctrl_wr = wr_i & hit(addr_i, mtc_pkg::CTRL_ADDR);
   assign uf      = tk.tick & run_r & ~first_r & ~rl_pend_r
                  & (ocnt_r == mtc_pkg::CNT_RST);
   assign uf_stop = uf & (omode_r != mtc_pkg::OM_CONT);

   ////////////////////////////////////////////////////////////////
   // enable priority: later assignment wins
   always_comb
   begin
      run_nxt = run_r;
      if (ext_start)
         run_nxt = 1'b1;
      if (uf_stop)
         run_nxt = 1'b0;
      if (ctrl_wr)
         run_nxt = wdata_i[mtc_pkg::RUN_BIT];
   end

   ////////////////////////////////////////////////////////////////
   // control and configuration registers
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         omode_r  <= mtc_pkg::OM_SINGLE;
         mmode_r  <= mtc_pkg::MM_FREE;
         cbus_r   <= 1'b0;
         run_r    <= 1'b0;
         div_r    <= '0;
         reload_r <= mtc_pkg::CNT_RST;
         ien_r    <= '0;
      end
      else
      begin
         run_r <= run_nxt;
         if (ctrl_wr)
         begin
            omode_r <= wdata_i[mtc_pkg::OMODE_LSB +: 2];
            mmode_r <= wdata_i[mtc_pkg::MMODE_LSB +: 2];
            cbus_r  <= wdata_i[mtc_pkg::CBUS_BIT];
         end
         if (wr_i && hit(addr_i, mtc_pkg::PRESC_ADDR))
            div_r <= wdata_i[mtc_pkg::PRE_W-1:0];
         if (wr_i && hit(addr_i, mtc_pkg::RELOAD_ADDR))
            reload_r <= wdata_i[mtc_pkg::CNT_W-1:0];
         if (wr_i && hit(addr_i, mtc_pkg::IEN_ADDR))
            ien_r <= wdata_i[mtc_pkg::ST_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // winning write re-arms; logic waits for the first tick
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         first_r <= 1'b0;
      else if (run_nxt && (!run_r || uf_stop))
         first_r <= 1'b1;
      else if (tk.tick)
         first_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // down counter; writes beat counting
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ocnt_r    <= mtc_pkg::CNT_RST;
         rl_pend_r <= 1'b0;
      end
      else
      begin
         rl_pend_r <= 1'b0;
         if (wr_i && hit(addr_i, mtc_pkg::OCNT_ADDR))
            ocnt_r <= wdata_i[mtc_pkg::CNT_W-1:0];
         // correction wraps silently; nothing flags it
         else if (wr_i && hit(addr_i, mtc_pkg::CORR_ADDR))
            ocnt_r <= ocnt_r + wdata_i[mtc_pkg::CNT_W-1:0];
         // transient ones become reload minus one
         else if (rl_pend_r)
            ocnt_r <= reload_r - mtc_pkg::CNT_ONE;
         else if (run_r && tk.tick && first_r)
            ocnt_r <= reload_r;
         // reload shows all ones for one cycle
         else if (uf && omode_r != mtc_pkg::OM_SINGLE)
         begin
            ocnt_r    <= mtc_pkg::CNT_ONES;
            rl_pend_r <= 1'b1;
         end
         else if (run_r && tk.tick && !uf)
            ocnt_r <= ocnt_r - mtc_pkg::CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////
   // output flop; idle until the first tick after enable
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ff_act_r <= 1'b0;
         ff_r     <= 1'b0;
      end
      else if (!run_r)
         ff_act_r <= 1'b0;
      else if (first_r && tk.tick)
      begin
         ff_act_r <= 1'b1;
         if (omode_r != mtc_pkg::OM_DELAYED)
            ff_r <= ~ff_r;
      end
      else if (uf && ff_act_r)
         ff_r <= ~ff_r;
   end

   assign timer_out_o = ff_r;

   ////////////////////////////////////////////////////////////////
   // measure capture value; off-rate clock bus leads by one count
   // capture skew
   assign skew    = cbus_r & (div_r != mtc_pkg::PRE_HALF);
   assign cap_val = skew ? mcnt_r + mtc_pkg::CNT_ONE : mcnt_r;

   ////////////////////////////////////////////////////////////////
   // up counter and measure register
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         mcnt_r <= mtc_pkg::CNT_RST;
         mcap_r <= mtc_pkg::CNT_RST;
      end
      else
      begin
         if (wr_i && hit(addr_i, mtc_pkg::MCNT_ADDR))
         begin
            mcnt_r <= wdata_i[mtc_pkg::CNT_W-1:0];
            if (mev && mmode_r != mtc_pkg::MM_LONG)
               mcap_r <= wdata_i[mtc_pkg::CNT_W-1:0];
            else if (mev)
               mcap_r <= cap_val;
         end
         else
         begin
            if (mev)
               mcap_r <= cap_val;
            if (mev && mmode_r == mtc_pkg::MM_CLEAR)
               mcnt_r <= mtc_pkg::CNT_RST;
            else if (tk.tick)
               mcnt_r <= mcnt_r + mtc_pkg::CNT_ONE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // sticky status, set beats clear
   assign ev_set = {mev, uf};
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         stat_r <= '0;
      else if (wr_i && hit(addr_i, mtc_pkg::ICLR_ADDR))
         stat_r <= (stat_r & ~wdata_i[mtc_pkg::ST_W-1:0]) | ev_set;
      else
         stat_r <= stat_r | ev_set;
   end

   // level interrupt, no register stage needed
   assign irq_o = |(stat_r & ien_r);

   ////////////////////////////////////////////////////////////////
   // read port; unmapped and write-only addresses read zero
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         rdata_r <= '0;
      else if (rd_i)
      begin
         unique case (addr_i)
            mtc_pkg::CTRL_ADDR:
               rdata_r <= {25'h0, cbus_r, mmode_r, 1'b0, run_r, omode_r};
            mtc_pkg::PRESC_ADDR:  rdata_r <= {24'h0, div_r};
            mtc_pkg::RELOAD_ADDR: rdata_r <= {16'h0, reload_r};
            mtc_pkg::OCNT_ADDR:   rdata_r <= {16'h0, ocnt_r};
            mtc_pkg::MCNT_ADDR:   rdata_r <= {16'h0, mcnt_r};
            mtc_pkg::MCAP_ADDR:   rdata_r <= {16'h0, mcap_r};
            mtc_pkg::STAT_ADDR:   rdata_r <= {30'h0, stat_r};
            mtc_pkg::IEN_ADDR:    rdata_r <= {30'h0, ien_r};
            default:              rdata_r <= '0;
         endcase
      end
   end
   assign rdata_o = rdata_r;

   ////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_uf_stop_wins:
      assert property (uf_stop && ext_start && !ctrl_wr |=> !run_r)
      else $error("external enable beat underflow stop");
   a_sw_enable_wins:
      assert property (uf_stop && ctrl_wr && wdata_i[mtc_pkg::RUN_BIT] |=> run_r)
      else $error("underflow stop beat enable write");
   a_sw_disable_wins:
      assert property (ext_start && ctrl_wr && !wdata_i[mtc_pkg::RUN_BIT] |=> !run_r)
      else $error("external enable beat disable write");
   a_corr_no_flag:
      assert property (wr_i && hit(addr_i, mtc_pkg::CORR_ADDR) && !uf
                       |=> stat_r[mtc_pkg::ST_UF] == $past(stat_r[mtc_pkg::ST_UF]))
      else $error("correction changed underflow flag");
   a_uf_flags:
      assert property (uf |=> stat_r[mtc_pkg::ST_UF])
      else $error("underflow not flagged");
   a_reload_ones:
      assert property (uf && omode_r != mtc_pkg::OM_SINGLE && !wr_i
                       |=> ocnt_r == mtc_pkg::CNT_ONES)
      else $error("counter not all ones after reload");
   a_reload_minus:
      assert property ((uf && omode_r != mtc_pkg::OM_SINGLE && !wr_i) ##1 !wr_i
                       |=> ocnt_r == reload_r - mtc_pkg::CNT_ONE)
      else $error("counter not reload minus one");
   a_ff_delay:
      assert property (first_r && !tk.tick |=> $stable(ff_r))
      else $error("output flop moved before a tick");
   a_ff_bound:
      assert property (($rose(run_r) && div_r == mtc_pkg::PRE_HALF && !wr_i) ##1 !wr_i
                       |-> ##[1:3] ff_act_r)
      else $error("output flop did not start");
   a_write_both:
      assert property (mev && wr_i && hit(addr_i, mtc_pkg::MCNT_ADDR)
                       && mmode_r != mtc_pkg::MM_LONG |=> mcap_r == mcnt_r)
      else $error("write not in both registers");
   a_long_prewrite:
      assert property (mev && wr_i && hit(addr_i, mtc_pkg::MCNT_ADDR)
                       && mmode_r == mtc_pkg::MM_LONG && !skew
                       |=> mcap_r == $past(mcnt_r))
      else $error("long capture took written value");
   a_capture_lead:
      assert property (mev && !wr_i |=> mcap_r == ($past(skew)
                       ? $past(mcnt_r) + mtc_pkg::CNT_ONE : $past(mcnt_r)))
      else $error("capture skew wrong");
   a_count_down:
      assert property (run_r && tk.tick && !first_r && !rl_pend_r && !uf && !wr_i
                       |=> ocnt_r == $past(ocnt_r) - mtc_pkg::CNT_ONE)
      else $error("down counter did not step");
   c_underflow:  cover property (uf && omode_r == mtc_pkg::OM_CONT);
   c_collide:    cover property (uf_stop && ext_start);
   c_long_write: cover property (mev && wr_i && mmode_r == mtc_pkg::MM_LONG);
   c_irq:        cover property ($rose(irq_o));
endmodule

// [multi_timer_collision_rules_tb.sv]
// testbench: collision and corner cases of the timer block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module multi_timer_collision_rules_tb;
   // design ports
   logic        clock_i, rst_i, wr_i, rd_i, timer_out_o, irq_o;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic        ext_enable_i, meas_event_i;
   // bench state
   logic        ext_go, meas_go;
   int          fail_count, n_checks;

   mtc_timer u_mtc_timer (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .ext_enable_i, .meas_event_i, .timer_out_o, .irq_o);
   mtc_pins_model u_mtc_pins_model (.clock_i, .rst_i, .ext_go_i(ext_go),
      .meas_go_i(meas_go), .ext_enable_o(ext_enable_i), .meas_event_o(meas_event_i));

   // 20 MHz clock
   always #25 clock_i = ~clock_i;

   ////////////////////////////////////////////////////////////////////////////////////////
   // bus cycles: strobe one cycle, then one idle edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(posedge clock_i);
   endtask
   // read data sampled mid-cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      d = rdata_o;
      @(posedge clock_i);
   endtask
   // pin rises at return edge; synced event acts 3 edges later
   task automatic fire(input logic m);
      if (m) meas_go <= 1'b1;
      else ext_go <= 1'b1;
      @(posedge clock_i);
      ext_go <= 1'b0;
      meas_go <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] d;
      wr(mtc_pkg::STAT_ADDR, 32'h3);
      rd(mtc_pkg::STAT_ADDR, d);
      `CHK(d, 32'h0)
      rd(mtc_pkg::OCNT_ADDR, d);
      `CHK(d, 32'h0)
      rd(mtc_pkg::CORR_ADDR, d);
      `CHK(d, 32'h0)
      rd(8'h28, d);
      `CHK(d, 32'h0)
   endtask

   // flop must not move at the enable edge itself
   task automatic t_start;
      int k;
      wr(mtc_pkg::PRESC_ADDR, 32'h3);
      wr(mtc_pkg::RELOAD_ADDR, 32'h2);
      addr_i <= mtc_pkg::CTRL_ADDR;
      wdata_i <= 32'h4;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(negedge clock_i);
      `CHK(timer_out_o, 1'b0)
      k = 0;
      while (timer_out_o !== 1'b1 && k < 8)
      begin
         @(negedge clock_i);
         k++;
      end
      `CHK(timer_out_o, 1'b1)
      repeat (40) @(posedge clock_i);
   endtask

   // underflow stop meets ext enable (w=0) or run write (w=1)
   task automatic t_collide(input logic w);
      logic [31:0] d;
      int k;
      wr(mtc_pkg::PRESC_ADDR, 32'h0);
      wr(mtc_pkg::RELOAD_ADDR, 32'h6);
      wr(mtc_pkg::CTRL_ADDR, 32'h4);
      k = 0;
      do begin @(negedge clock_i); k++; end while (timer_out_o !== 1'b1 && k < 40);
      do begin @(negedge clock_i); k++; end while (timer_out_o !== 1'b0 && k < 40);
      @(posedge clock_i);
      wr(mtc_pkg::CTRL_ADDR, 32'h4);
      if (w)
      begin
         repeat (k - 2) @(posedge clock_i);
         wr(mtc_pkg::CTRL_ADDR, 32'h4);
      end
      else
      begin
         repeat (k - 5) @(posedge clock_i);
         fire(1'b0);
         repeat (3) @(posedge clock_i);
      end
      rd(mtc_pkg::CTRL_ADDR, d);
      `CHK(d[2], w)
      repeat (30) @(posedge clock_i);
   endtask

   // ext enable meets a disabling write, every output mode
   task automatic t_disable;
      logic [31:0] d;
      for (int m = 0; m < 3; m++)
      begin
         wr(mtc_pkg::CTRL_ADDR, m);
         fire(1'b0);
         repeat (2) @(posedge clock_i);
         wr(mtc_pkg::CTRL_ADDR, m);
         repeat (4) @(posedge clock_i);
         rd(mtc_pkg::CTRL_ADDR, d);
         `CHK(d[2], 1'b0)
      end
   endtask

   // back-to-back counter reads across the reload
   task automatic t_reload(input logic [1:0] om);
      logic [31:0] v [16];
      logic found;
      wr(mtc_pkg::PRESC_ADDR, 32'h0);
      wr(mtc_pkg::RELOAD_ADDR, 32'h4);
      wr(mtc_pkg::CTRL_ADDR, {29'h0, 1'b1, om});
      addr_i <= mtc_pkg::OCNT_ADDR;
      rd_i <= 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clock_i);
         @(negedge clock_i);
         v[i] = rdata_o;
      end
      @(posedge clock_i);
      rd_i <= 1'b0;
      found = 1'b0;
      for (int i = 1; i < 13; i++)
         if (!found && v[i] === 32'hffff)
         begin
            found = 1'b1;
            `CHK(v[i-1], 32'h0)
            `CHK(v[i+1], 32'h3)
            `CHK(v[i+2], (om == mtc_pkg::OM_CONT) ? 32'h2 : 32'h3)
         end
      `CHK(found, 1'b1)
      wr(mtc_pkg::CTRL_ADDR, {30'h0, om});
   endtask

   // wrap by correction: no flag then, flag at next underflow
   task automatic t_corr;
      logic [31:0] d;
      int k;
      wr(mtc_pkg::IEN_ADDR, 32'h3);
      wr(mtc_pkg::ICLR_ADDR, 32'h3);
      wr(mtc_pkg::RELOAD_ADDR, 32'h40);
      wr(mtc_pkg::CTRL_ADDR, 32'h5);
      wr(mtc_pkg::CORR_ADDR, 32'hfff0);
      @(negedge clock_i);
      `CHK(irq_o, 1'b0)
      @(posedge clock_i);
      rd(mtc_pkg::STAT_ADDR, d);
      `CHK(d, 32'h0)
      k = 0;
      while (irq_o !== 1'b1 && k < 100)
      begin
         @(negedge clock_i);
         k++;
      end
      `CHK(irq_o, 1'b1)
      @(posedge clock_i);
      rd(mtc_pkg::STAT_ADDR, d);
      `CHK(d, 32'h1)
      wr(mtc_pkg::IEN_ADDR, 32'h0);
      `CHK(irq_o, 1'b0)
      wr(mtc_pkg::ICLR_ADDR, 32'h1);
      wr(mtc_pkg::IEN_ADDR, 32'h3);
      rd(mtc_pkg::STAT_ADDR, d);
      `CHK(d, 32'h0)
      `CHK(irq_o, 1'b0)
   endtask

   // one capture trial; w puts a counter write on the event edge
   task automatic meas(input logic [1:0] m, input logic cb, input logic [7:0] dv,
                       input logic w, output logic [31:0] cap);
      wr(mtc_pkg::PRESC_ADDR, {24'h0, dv});
      wr(mtc_pkg::CTRL_ADDR, {26'h0, m, 4'h0});
      // counter written only with clock bus one off
      wr(mtc_pkg::MCNT_ADDR, 32'h0);
      wr(mtc_pkg::CTRL_ADDR, {25'h0, cb, m, 4'h0});
      fire(1'b1);
      repeat (2) @(posedge clock_i);
      if (w) wr(mtc_pkg::MCNT_ADDR, 32'h345);
      else repeat (2) @(posedge clock_i);
      repeat (4) @(posedge clock_i);
      rd(mtc_pkg::MCAP_ADDR, cap);
   endtask

   task automatic t_capture;
      logic [31:0] a, b;
      meas(2'h0, 1'b0, 8'h0, 1'b1, a);
      `CHK(a, 32'h345)
      meas(2'h1, 1'b0, 8'h0, 1'b1, a);
      `CHK(a, 32'h345)
      meas(2'h2, 1'b0, 8'h0, 1'b0, b);
      meas(2'h2, 1'b0, 8'h0, 1'b1, a);
      `CHK(a, b)
      meas(2'h2, 1'b1, 8'h0, 1'b0, a);
      `CHK(a, b + 32'h1)
      meas(2'h2, 1'b0, mtc_pkg::PRE_HALF, 1'b0, b);
      meas(2'h2, 1'b1, mtc_pkg::PRE_HALF, 1'b0, a);
      `CHK(a, b)
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog well beyond the several hundred cycles the run needs
   initial
   begin
      #400000;
      fail_count++;
      test_done();
   end

   // main sequence
   initial
   begin
      {clock_i, wr_i, rd_i, ext_go, meas_go, addr_i, wdata_i} = '0;
      rst_i = 1'b1;
      fail_count = 0;
      n_checks = 0;
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      t_regs();
      t_start();
      t_collide(1'b0);
      t_collide(1'b1);
      t_disable();
      t_reload(2'h1);
      t_reload(2'h2);
      t_corr();
      t_capture();
      test_done();
   end
endmodule
